// >>> logic/rbdis_top.sv
// Notes on behaviour
// - While reset pin is low, outputs idle, no DRAM or screen refresh.
// - Host-select sampled in the cycle before reset release chooses start mode.
// - Host-select high at release: stay halted while halt bit is set.
// - Refresh keeps running while halted in host-present mode.
// - After halt clears, fetch reset vector from top-of-memory and run.
// - Host-select low: eight refreshes, then fetch vector and run at once.
// - Vector's four low bits load byte order, protect and row/column config bits.
// - Reset and trap-0 use the reset vector without stacking status or pointer.
// - Host nonmaskable request taken; no-stack mode bit suppresses state save.
// - Reset held at least four clocks; internal reset lasts 34 local clocks.
// - During internal reset after pin release, refresh cycles continue.
// - Reset release forces first quarter phase; aligned within 10 quarters.
// - Eight column-first refreshes after every reset before memory grant.
// - After reset, one refresh every eight local clock periods.
// - Reset clears all registers except halt bit, which takes host-select.
`timescale 1ns/1ps
`default_nettype none
`include "rbdis_defines.svh"
module rbdis_top (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic rstn, // Async reset, active low
    input wire logic reset_pin_n, // Device reset pin, active low
    input wire logic host_select_input, // Host-select pin
    input wire logic hsel, // AHB select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic [31:0] hrdata, // AHB read data
    output logic hresp, // AHB response
    input wire logic vec_ack, // Vector read done
    input wire logic [31:0] vec_data, // Vector read value
    input wire logic trap0_req, // Trap-0 executed
    output logic vec_req, // Vector read request
    output logic [31:0] vec_addr, // Vector address
    output logic [31:0] boot_pc, // Start instruction_pointer
    output logic push_inhibit, // No stack save for this entry
    output logic cpu_run, // Execution enabled
    output logic mem_grant, // Memory access allowed
    output logic refresh_req, // column_first_refresh pulse
    output logic nmi_take, // Nonmaskable interrupt pulse
    output logic nmi_nostack, // Skip state save on this interrupt
    output logic [1:0] quarter_phase // Current quarter phase
);
    logic [1:0] pins_s;
    logic pin_s;
    logic hs_s;
    logic pin_d_reg;
    logic hs_d_reg;
    logic pin_rise;
    logic tick;
    logic [1:0] qphase;

    rbdis_sync #(.W(2)) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in({host_select_input, reset_pin_n}),
        .sync_out(pins_s)
    );
    assign pin_s = pins_s[0];
    assign hs_s = pins_s[1];
    assign pin_rise = pin_s & ~pin_d_reg;

    rbdis_quarter u_quarter (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .align(pin_rise),
        .phase(qphase),
        .tick(tick)
    );

    // Host-select held one cycle: the value just before release
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_d_reg <= 1'b0;
            hs_d_reg <= 1'b0;
        end else begin
            pin_d_reg <= pin_s;
            hs_d_reg <= hs_s;
        end
    end

    // Bus slave state
    logic dp_wr_reg;
    logic dp_wr_next;
    logic [7:0] dp_addr_reg;
    logic [7:0] dp_addr_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic hreadyout_reg;
    logic hresp_reg;
    logic aph;
    logic wr_hc;
    logic wr_cfg;
    logic wr_rf;

    // Software-visible registers
    logic halt_reg;
    logic halt_next;
    logic nmi_reg;
    logic nmi_next;
    logic nostack_reg;
    logic nostack_next;
    logic [`RBDIS_CFG_W-1:0] cfg_reg;
    logic [`RBDIS_CFG_W-1:0] cfg_next;
    logic [7:0] rfint_reg;
    logic [7:0] rfint_next;

    // Sequencer state
    rbdis_pkg::rbdis_state_t state_reg;
    rbdis_pkg::rbdis_state_t state_next;
    logic [5:0] lcnt_reg;
    logic [5:0] lcnt_next;
    logic [3:0] rcnt_reg;
    logic [3:0] rcnt_next;
    logic [7:0] rtimer_reg;
    logic [7:0] rtimer_next;
    logic [7:0] ivl;
    logic rst_fetch_reg;
    logic rst_fetch_next;
    logic refresh_reg;
    logic refresh_next;
    logic cpu_run_reg;
    logic mem_grant_reg;
    logic vec_req_reg;
    logic push_inh_reg;
    logic [31:0] boot_pc_reg;
    logic [31:0] boot_pc_next;
    logic [31:0] vec_addr_reg;
    logic nmi_take_reg;
    logic nmi_take_next;
    logic nmi_ns_reg;
    logic take_vec;

    assign aph = hsel & htrans[1] & hready;
    assign wr_hc = dp_wr_reg & (dp_addr_reg == `RBDIS_OFF_HOSTCTL);
    assign wr_cfg = dp_wr_reg & (dp_addr_reg == `RBDIS_OFF_CONFIG);
    assign wr_rf = dp_wr_reg & (dp_addr_reg == `RBDIS_OFF_RFINT);
    assign take_vec = (state_reg == rbdis_pkg::ST_FETCH) & vec_req_reg
        & vec_ack;

    always_comb begin
        dp_wr_next = aph & hwrite;
        dp_addr_next = dp_addr_reg;
        hrdata_next = hrdata_reg;
        if (aph) begin
            dp_addr_next = haddr[7:0];
        end
        if (aph && !hwrite) begin
            unique case (haddr[7:0])
                `RBDIS_OFF_HOSTCTL: hrdata_next = {29'h0, nostack_reg,
                    nmi_reg, halt_reg};
                `RBDIS_OFF_CONFIG: hrdata_next = {24'h0, cfg_reg};
                `RBDIS_OFF_RFINT: hrdata_next = {24'h0, rfint_reg};
                `RBDIS_OFF_STATUS: hrdata_next = {20'h0, state_reg,
                    rcnt_reg, qphase};
                default: hrdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dp_wr_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
            hrdata_reg <= 32'h0;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end else begin
            dp_wr_reg <= dp_wr_next;
            dp_addr_reg <= dp_addr_next;
            hrdata_reg <= hrdata_next;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end
    end

    // Registers: cleared while reset pin low, halt loaded at release
    always_comb begin
        halt_next = halt_reg;
        nmi_next = nmi_reg & ~nmi_take_next;
        nostack_next = nostack_reg;
        cfg_next = cfg_reg;
        rfint_next = rfint_reg;
        if (wr_hc) begin
            halt_next = hwdata[`RBDIS_HC_HALT];
            nostack_next = hwdata[`RBDIS_HC_NOSTACK];
            if (hwdata[`RBDIS_HC_NMI]) begin
                nmi_next = 1'b1;
            end
        end
        if (wr_cfg && !cfg_reg[`RBDIS_CFG_CBP]) begin
            cfg_next = hwdata[`RBDIS_CFG_W-1:0];
        end
        if (wr_rf) begin
            rfint_next = hwdata[7:0];
        end
        if (take_vec && rst_fetch_reg) begin
            cfg_next[`RBDIS_CFG_VEC_MSB:0] =
                vec_data[`RBDIS_CFG_VEC_MSB:0];
        end
        if (state_reg == rbdis_pkg::ST_HELD) begin
            halt_next = pin_rise ? hs_d_reg : 1'b0;
            nmi_next = 1'b0;
            nostack_next = 1'b0;
            cfg_next = `RBDIS_CFG_RST;
            rfint_next = `RBDIS_RFINT_RST;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            halt_reg <= 1'b0;
            nmi_reg <= 1'b0;
            nostack_reg <= 1'b0;
            cfg_reg <= `RBDIS_CFG_RST;
            rfint_reg <= `RBDIS_RFINT_RST;
        end else begin
            halt_reg <= halt_next;
            nmi_reg <= nmi_next;
            nostack_reg <= nostack_next;
            cfg_reg <= cfg_next;
            rfint_reg <= rfint_next;
        end
    end

    // Zero in the interval register selects the fast post-reset rate
    assign ivl = (rfint_reg == 8'h00) ? `RBDIS_FAST_RFINT : rfint_reg;

    always_comb begin
        state_next = state_reg;
        lcnt_next = lcnt_reg;
        rcnt_next = rcnt_reg;
        rtimer_next = rtimer_reg;
        rst_fetch_next = rst_fetch_reg;
        refresh_next = 1'b0;
        boot_pc_next = boot_pc_reg;
        nmi_take_next = 1'b0;
        if (state_reg != rbdis_pkg::ST_HELD && tick) begin
            if (rtimer_reg >= ivl - 8'h01) begin
                rtimer_next = 8'h00;
                refresh_next = 1'b1;
            end else begin
                rtimer_next = rtimer_reg + 8'h01;
            end
        end
        unique case (state_reg)
            rbdis_pkg::ST_HELD: begin
                lcnt_next = 6'h00;
                rcnt_next = 4'h0;
                rtimer_next = 8'h00;
                refresh_next = 1'b0;
                if (pin_rise) begin
                    state_next = rbdis_pkg::ST_INTRST;
                end
            end
            rbdis_pkg::ST_INTRST: begin
                if (tick) begin
                    lcnt_next = lcnt_reg + 6'h01;
                    if (lcnt_reg == `RBDIS_INTRST_LAST) begin
                        state_next = rbdis_pkg::ST_INIT;
                        rcnt_next = 4'h0;
                    end
                end
            end
            rbdis_pkg::ST_INIT: begin
                if (refresh_next) begin
                    rcnt_next = rcnt_reg + 4'h1;
                    if (rcnt_reg == `RBDIS_INIT_LAST) begin
                        rst_fetch_next = 1'b1;
                        state_next = halt_reg ? rbdis_pkg::ST_HALT
                            : rbdis_pkg::ST_FETCH;
                    end
                end
            end
            rbdis_pkg::ST_HALT: begin
                nmi_take_next = nmi_reg;
                if (!halt_reg) begin
                    state_next = rbdis_pkg::ST_FETCH;
                end
            end
            rbdis_pkg::ST_FETCH: begin
                if (take_vec) begin
                    boot_pc_next = {vec_data[31:4], 4'h0};
                    state_next = rbdis_pkg::ST_RUN;
                end
            end
            rbdis_pkg::ST_RUN: begin
                nmi_take_next = nmi_reg;
                if (trap0_req) begin
                    rst_fetch_next = 1'b0;
                    state_next = rbdis_pkg::ST_FETCH;
                end
            end
        endcase
        if (!pin_s) begin
            state_next = rbdis_pkg::ST_HELD;
            refresh_next = 1'b0;
            nmi_take_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= rbdis_pkg::ST_HELD;
            lcnt_reg <= 6'h00;
            rcnt_reg <= 4'h0;
            rtimer_reg <= 8'h00;
            rst_fetch_reg <= 1'b0;
            refresh_reg <= 1'b0;
            cpu_run_reg <= 1'b0;
            mem_grant_reg <= 1'b0;
            vec_req_reg <= 1'b0;
            push_inh_reg <= 1'b0;
            boot_pc_reg <= 32'h0;
            vec_addr_reg <= 32'h0;
            nmi_take_reg <= 1'b0;
            nmi_ns_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            lcnt_reg <= lcnt_next;
            rcnt_reg <= rcnt_next;
            rtimer_reg <= rtimer_next;
            rst_fetch_reg <= rst_fetch_next;
            refresh_reg <= refresh_next;
            cpu_run_reg <= (state_next == rbdis_pkg::ST_RUN) & ~halt_next;
            mem_grant_reg <= (state_next == rbdis_pkg::ST_HALT)
                | (state_next == rbdis_pkg::ST_FETCH)
                | (state_next == rbdis_pkg::ST_RUN);
            vec_req_reg <= (state_next == rbdis_pkg::ST_FETCH);
            push_inh_reg <= (state_next == rbdis_pkg::ST_FETCH);
            boot_pc_reg <= boot_pc_next;
            vec_addr_reg <= `RBDIS_VEC_ADDR;
            nmi_take_reg <= nmi_take_next;
            nmi_ns_reg <= nmi_take_next ? nostack_reg : nmi_ns_reg;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hrdata = hrdata_reg;
    assign hresp = hresp_reg;
    assign vec_req = vec_req_reg;
    assign vec_addr = vec_addr_reg;
    assign boot_pc = boot_pc_reg;
    assign push_inhibit = push_inh_reg;
    assign cpu_run = cpu_run_reg;
    assign mem_grant = mem_grant_reg;
    assign refresh_req = refresh_reg;
    assign nmi_take = nmi_take_reg;
    assign nmi_nostack = nmi_ns_reg;
    assign quarter_phase = qphase;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Refresh gap counter for the interval check
    logic [7:0] gap_reg;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            gap_reg <= 8'h00;
        end else begin
            gap_reg <= refresh_reg ? 8'h01 : gap_reg + 8'h01;
        end
    end

    property p_held_quiet;
        (state_reg == rbdis_pkg::ST_HELD) |-> !refresh_reg && !cpu_run_reg
            && !mem_grant_reg && !vec_req_reg;
    endproperty
    a_held_quiet: assert property (p_held_quiet)
        else $error("activity while reset held");

    property p_halt_sample;
        (state_reg == rbdis_pkg::ST_HELD) && pin_rise
            |=> halt_reg == $past(hs_d_reg);
    endproperty
    a_halt_sample: assert property (p_halt_sample)
        else $error("halt bit not loaded from host select");

    property p_halted_no_run;
        halt_reg |-> !cpu_run_reg;
    endproperty
    a_halted_no_run: assert property (p_halted_no_run)
        else $error("running while halt bit set");

    property p_intrst_len;
        (state_reg == rbdis_pkg::ST_INTRST) && pin_s
            && (state_next == rbdis_pkg::ST_INIT)
            |-> lcnt_reg == `RBDIS_INTRST_LAST && tick;
    endproperty
    a_intrst_len: assert property (p_intrst_len)
        else $error("internal reset left at wrong count");

    property p_grant_after_init;
        $rose(mem_grant_reg) |-> $past(rcnt_reg) == `RBDIS_INIT_LAST
            && $past(refresh_next);
    endproperty
    a_grant_after_init: assert property (p_grant_after_init)
        else $error("memory granted before eight refreshes");

    property p_fast_rate;
        refresh_reg && $past(refresh_reg, 32) && rfint_reg == 8'h00
            && $stable(rfint_reg) |-> gap_reg == 8'h20;
    endproperty
    a_fast_rate: assert property (p_fast_rate)
        else $error("refresh gap not eight local clocks");

    property p_vector_fetch;
        vec_req_reg |-> vec_addr_reg == `RBDIS_VEC_ADDR && push_inh_reg;
    endproperty
    a_vector_fetch: assert property (p_vector_fetch)
        else $error("vector fetch address or stacking wrong");

    property p_vec_cfg;
        take_vec && rst_fetch_reg && pin_s
            |=> cfg_reg[3:0] == $past(vec_data[3:0]) && cpu_run_reg
            == !halt_reg;
    endproperty
    a_vec_cfg: assert property (p_vec_cfg)
        else $error("configuration not loaded from vector");

    property p_nmi_mode;
        nmi_take_reg |-> nmi_nostack == $past(nostack_reg) && !nmi_reg;
    endproperty
    a_nmi_mode: assert property (p_nmi_mode)
        else $error("nonmaskable take mode mismatch");

    c_host_boot: cover property (state_reg == rbdis_pkg::ST_HALT
        ##[1:200] state_reg == rbdis_pkg::ST_RUN);
    c_self_boot: cover property (state_reg == rbdis_pkg::ST_INIT
        ##1 state_reg == rbdis_pkg::ST_FETCH);
    c_trap0: cover property (state_reg == rbdis_pkg::ST_RUN && trap0_req);
    c_nmi: cover property (nmi_take_reg && nmi_nostack);
endmodule : rbdis_top
`default_nettype wire

// >>> logic/rbdis_defines.svh
`ifndef RBDIS_DEFINES_SVH
`define RBDIS_DEFINES_SVH

// Register byte offsets
`define RBDIS_OFF_HOSTCTL 8'h00
`define RBDIS_OFF_CONFIG 8'h04
`define RBDIS_OFF_RFINT 8'h08
`define RBDIS_OFF_STATUS 8'h0C

// host_control_high fields
`define RBDIS_HC_HALT 0
`define RBDIS_HC_NMI 1
`define RBDIS_HC_NOSTACK 2

// Configuration fields: bit0 byte order, bit1 protect, bits 3:2 row/column
`define RBDIS_CFG_CBP 1
`define RBDIS_CFG_VEC_MSB 3
`define RBDIS_CFG_W 8

// Reset values
`define RBDIS_CFG_RST 8'h00
`define RBDIS_RFINT_RST 8'h00

// Level-0 vector location
`define RBDIS_VEC_ADDR 32'hFFFFFFE0

// Timing counts, in local clock periods; the init count is in refreshes
`define RBDIS_INTRST_LAST 6'h21
`define RBDIS_INIT_LAST 4'h7
`define RBDIS_FAST_RFINT 8'h08

// Quarter phases: one ref_clk cycle each, four per local clock
`define RBDIS_QPHASE_FIRST 2'h0
`define RBDIS_QPHASE_LAST 2'h3
`define RBDIS_QUARTERS 4

`endif

// >>> logic/rbdis_pkg.sv
package rbdis_pkg;
    typedef enum logic [5:0] {
        ST_HELD   = 6'h01,
        ST_INTRST = 6'h02,
        ST_INIT   = 6'h04,
        ST_HALT   = 6'h08,
        ST_FETCH  = 6'h10,
        ST_RUN    = 6'h20
    } rbdis_state_t;
endpackage : rbdis_pkg

// >>> logic/rbdis_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rbdis_sync #(
    parameter int W = 2
) (
    input wire logic ref_clk, // Clock
    input wire logic rstn, // Async reset, active low
    input wire logic [W-1:0] async_in, // Pin levels
    output logic [W-1:0] sync_out // Synchronised levels
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                end else begin
                    s1_reg <= async_in[i];
                    s2_reg <= s1_reg;
                end
            end
            assign sync_out[i] = s2_reg;
        end
    endgenerate
endmodule : rbdis_sync
`default_nettype wire

// >>> logic/rbdis_quarter.sv
`timescale 1ns/1ps
`default_nettype none
`include "rbdis_defines.svh"
module rbdis_quarter (
    input wire logic ref_clk, // Clock, one quarter cycle per period
    input wire logic rstn, // Async reset, active low
    input wire logic align, // Pulse on reset pin release
    output logic [1:0] phase, // Current quarter phase
    output logic tick // Pulse once per local clock period
);
    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        phase_next = phase_reg + 2'h1;
        if (align) begin
            phase_next = `RBDIS_QPHASE_FIRST;
        end
        tick_next = (phase_next == `RBDIS_QPHASE_LAST);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= `RBDIS_QPHASE_FIRST;
            tick_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            tick_reg <= tick_next;
        end
    end

    assign phase = phase_reg;
    assign tick = tick_reg;

    property p_phase_align;
        @(posedge ref_clk) disable iff (!rstn)
        align |=> (phase_reg == `RBDIS_QPHASE_FIRST);
    endproperty
    a_phase_align: assert property (p_phase_align)
        else $error("quarter phase not aligned after reset release");

    property p_tick_spacing;
        @(posedge ref_clk) disable iff (!rstn)
        tick_reg |=> !tick_reg [*3];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("local clock tick closer than four quarters");
endmodule : rbdis_quarter
`default_nettype wire

// >>> bench/rbdis_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module rbdis_mem_model (
    input wire logic ref_clk, // Clock
    input wire logic vec_req, // Vector read request
    input wire logic [3:0] dly, // Answer delay in cycles
    input wire logic [31:0] value, // Vector word to return
    output logic vec_ack, // Vector read done
    output logic [31:0] vec_data // Vector word, junk when idle
);
    logic [3:0] cnt;
    initial begin
        vec_ack = 1'b0;
        vec_data = 32'h0;
        cnt = 4'h0;
    end
    always @(posedge ref_clk) begin
        if (vec_req && !vec_ack && cnt >= dly) begin
            vec_ack <= 1'b1;
            vec_data <= value;
            cnt <= 4'h0;
        end else begin
            vec_ack <= 1'b0;
            vec_data <= ~vec_data; // Idle bus never holds the last word
            cnt <= (vec_req && !vec_ack) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule : rbdis_mem_model
`default_nettype wire

// >>> bench/rbdis_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module rbdis_top_test;
    logic ref_clk, rstn, reset_pin_n, host_select_input, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, vec_data, vec_addr, boot_pc, v, v_mem;
    logic [1:0] htrans, quarter_phase;
    logic [2:0] hsize;
    logic [3:0] dly, cfg;
    logic hreadyout, hresp, vec_ack, trap0_req, vec_req, push_inhibit;
    logic cpu_run, mem_grant, refresh_req, nmi_take, nmi_nostack;
    logic rd_dp, bad;
    logic [31:0] exp_q[$];
    int mismatches, n_tests, cyc, n, c;

    always #5 ref_clk = ~ref_clk;

    rbdis_top i_rbdis_top (.ref_clk(ref_clk), .rstn(rstn),
        .reset_pin_n(reset_pin_n), .host_select_input(host_select_input),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .vec_ack(vec_ack), .vec_data(vec_data), .trap0_req(trap0_req),
        .vec_req(vec_req), .vec_addr(vec_addr), .boot_pc(boot_pc),
        .push_inhibit(push_inhibit), .cpu_run(cpu_run),
        .mem_grant(mem_grant), .refresh_req(refresh_req),
        .nmi_take(nmi_take), .nmi_nostack(nmi_nostack),
        .quarter_phase(quarter_phase));

    rbdis_mem_model i_rbdis_mem_model (.ref_clk(ref_clk), .vec_req(vec_req),
        .dly(dly), .value(v_mem), .vec_ack(vec_ack), .vec_data(vec_data));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task summarize;
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // Read data checked against the oldest note at the data phase edge
    always @(posedge ref_clk) begin
        if (rd_dp)
            chk(hrdata, exp_q.pop_front());
        rd_dp <= hsel && htrans == 2'h2 && !hwrite && hreadyout;
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task tick;
        @(posedge ref_clk);
        #1;
    endtask : tick

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        tick;
        while (hreadyout !== 1'b1) tick;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        tick;
        while (hreadyout !== 1'b1) tick;
    endtask : ahb

    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask : rd

    task fetch(input logic [31:0] val);
        c = 0;
        while (vec_req !== 1'b1 && c < 20) begin
            tick;
            c++;
        end
        chk(c < 20, 1'b1);
        chk(vec_addr, 32'hFFFFFFE0);
        chk(push_inhibit, 1'b1);
        while (vec_req === 1'b1) tick;
        tick;
        chk(boot_pc, {val[31:4], 4'h0});
        chk(cpu_run, 1'b1);
    endtask : fetch

    task pin_reset(input logic hs, input logic [3:0] d, input int hold);
        v = $urandom;
        v_mem <= v;
        dly <= d;
        host_select_input <= hs;
        reset_pin_n <= 1'b0;
        n = 0;
        c = 0;
        repeat (hold + $urandom % 8) begin
            tick;
            c++;
            // A refresh already launched before the pin is synced may show
            if (c > 3 && refresh_req !== 1'b0) n++;
        end
        chk(n, 0);
        chk({cpu_run, mem_grant, vec_req}, 3'h0);
        reset_pin_n <= 1'b1;
        n = 0;
        c = 0;
        while (mem_grant !== 1'b1 && c < 2000) begin
            tick;
            c++;
            if (refresh_req === 1'b1) n++;
            if (c == 12) begin
                // Phase forced to first quarter three edges after release
                chk(quarter_phase, 2'h1);
            end
        end
        chk(n >= 8, 1'b1);
        chk(c >= 360 && c < 2000, 1'b1);
    endtask : pin_reset

    initial begin
        ref_clk = 0; rstn = 0; reset_pin_n = 0; host_select_input = 0;
        hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
        hwdata = 0; trap0_req = 0; dly = 0; v_mem = 0; rd_dp = 0;
        mismatches = 0; n_tests = 0; cyc = 0;
        v = $urandom(21);
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        tick;
        pin_reset(1'b0, 4'h0, 160);
        fetch(v);
        rd(8'h04, {28'h0, v[3:0]});
        rd(8'h00, 32'h0);
        rd(8'h10, 32'h0);
        pin_reset(1'b1, 4'h5, 16);
        rd(8'h00, 32'h1);
        n = 0;
        bad = 1'b0;
        repeat (100) begin
            tick;
            if (refresh_req === 1'b1) n++;
            if (cpu_run !== 1'b0 || vec_req !== 1'b0) bad = 1'b1;
        end
        chk(n >= 3, 1'b1);
        chk(bad, 1'b0);
        while (refresh_req !== 1'b1) tick;
        c = 0;
        do begin
            tick;
            c++;
        end while (refresh_req !== 1'b1 && c < 100);
        chk(c, 32);
        ahb(1'b1, 8'h00, 32'h0);
        fetch(v);
        rd(8'h04, {28'h0, v[3:0]});
        for (int m = 0; m < 2; m++) begin
            ahb(1'b1, 8'h00, {29'h0, m[0], 2'h2});
            c = 0;
            while (nmi_take !== 1'b1 && c < 10) begin
                tick;
                c++;
            end
            chk(c < 10, 1'b1);
            tick;
            chk(nmi_nostack, m[0]);
            rd(8'h00, {29'h0, m[0], 2'h0});
        end
        cfg = v[3:0];
        v = $urandom;
        v_mem <= v;
        trap0_req <= 1'b1;
        tick;
        trap0_req <= 1'b0;
        fetch(v);
        rd(8'h04, {28'h0, cfg});
        summarize();
    end
endmodule : rbdis_top_test
`default_nettype wire
